// *** rtl/lsp_load_store_unit.sv ***
// Summary of operation
// - Loads and stores of words, halfwords and bytes are supported.
// - At most two granted transactions await response; no request queue.
// - Request stays high until grant seen high for one cycle.
// - Address phase signals hold stable until the cycle after grant.
// - Write enable high for stores, low for loads, with request.
// - Four-bit byte enable marks lanes accessed, with request.
// - Store data word presented with request through address phase.
// - Transaction accepted only when request and grant both high.
// - Optional id, user, ready and error signals are not implemented.
// - No misaligned exception; misaligned accesses handled in hardware.
// - Split non-aligned words and word-crossing halfwords into two transactions.
// - Split access issues lower address part first.
// - Post-increment uses base address, writes back base plus offset.
`timescale 1ns/100ps
`default_nettype none
module lsp_load_store_unit
   import lsp_pkg::*;
#(
   parameter bit custom_isa_extension_enable = 1'b0
) (
   input wire logic core_clk, // Clock
   input wire logic sys_rst, // Sync reset, active high
   input wire logic op_valid, // Operation offered
   output logic op_ready, // Operation accepted
   input wire lsp_op_s op, // Operation fields
   output logic res_valid, // Result pulse
   output lsp_res_s res, // Result data
   output logic mem_req, // Bus request
   input wire logic mem_gnt, // Bus grant
   output lsp_addr_s mem_out, // Address phase
   input wire logic mem_rvalid, // Response valid
   input wire logic [31:0] mem_rdata // Response data
);

   typedef enum logic [1:0] {
      LSP_IDLE,
      LSP_REQ_LO,
      LSP_REQ_HI,
      LSP_WAIT
   } lsp_state_e;

   lsp_state_e state, next_state;
   lsp_addr_s mem_out_r, next_mem_out;
   logic [31:0] hi_addr, next_hi_addr;
   logic [3:0] hi_be, next_hi_be;
   logic [31:0] hi_wdata, next_hi_wdata;
   logic split, next_split;
   logic [1:0] ofs, next_ofs;
   lsp_size_e size, next_size;
   logic sext, next_sext;
   logic wr, next_wr;
   logic [31:0] lo_data, next_lo_data;
   logic got_lo, next_got_lo;
   logic [1:0] outst, next_outst;
   logic res_v, next_res_v;
   lsp_res_s res_r, next_res;

   logic [31:0] eff_addr;
   logic [7:0] be_wide;
   logic [63:0] wd_wide;
   logic [63:0] rd_wide;
   logic [31:0] rd_shift;
   logic accept;
   logic granted;

   function automatic logic [3:0] size_be(input lsp_size_e s);
      unique case (s)
         LSP_SIZE_BYTE: size_be = LSP_BE_BYTE;
         LSP_SIZE_HALF: size_be = LSP_BE_HALF;
         default: size_be = LSP_BE_WORD;
      endcase
   endfunction

   assign eff_addr = op.post_inc && custom_isa_extension_enable ? op.base : op.base + op.offset;
   assign be_wide = {4'h0, size_be(op.size)} << eff_addr[1:0];
   assign wd_wide = {32'h0, op.wdata} << {eff_addr[1:0], 3'h0};
   assign op_ready = (state == LSP_IDLE) && !res_v;
   assign accept = op_valid && op_ready;
   assign granted = mem_req && mem_gnt;
   assign mem_req = (state == LSP_REQ_LO) || (state == LSP_REQ_HI);
   assign mem_out = mem_out_r;
   assign res_valid = res_v;
   assign res = res_r;
   assign rd_wide = {mem_rdata, lo_data};
   assign rd_shift = split ? 32'(rd_wide >> {ofs, 3'h0}) : mem_rdata >> {ofs, 3'h0};

   always_comb begin
      next_state = state;
      next_mem_out = mem_out_r;
      next_hi_addr = hi_addr;
      next_hi_be = hi_be;
      next_hi_wdata = hi_wdata;
      next_split = split;
      next_ofs = ofs;
      next_size = size;
      next_sext = sext;
      next_wr = wr;
      next_lo_data = lo_data;
      next_got_lo = got_lo;
      next_outst = outst;
      next_res_v = 1'b0;
      next_res = res_r;
      next_res.base_wb_en = 1'b0;
      if (granted && !(mem_rvalid && outst != 2'h0)) begin
         next_outst = outst + 2'h1;
      end else if (!granted && mem_rvalid && outst != 2'h0) begin
         next_outst = outst - 2'h1;
      end
      unique case (state)
         LSP_IDLE: begin
            if (accept) begin
               next_split = be_wide[7:4] != LSP_BE_NONE;
               next_ofs = eff_addr[1:0];
               next_size = op.size;
               next_sext = op.sign_ext;
               next_wr = op.write;
               next_got_lo = 1'b0;
               next_mem_out.addr = {eff_addr[31:2], LSP_WORD_OFS_W};
               next_mem_out.we = op.write;
               next_mem_out.be = be_wide[3:0];
               next_mem_out.wdata = wd_wide[31:0];
               next_hi_addr = {eff_addr[31:2] + 30'h1, LSP_WORD_OFS_W};
               next_hi_be = be_wide[7:4];
               next_hi_wdata = wd_wide[63:32];
               next_res.base_wb = op.base + op.offset;
               next_state = LSP_REQ_LO;
            end
         end
         LSP_REQ_LO: begin
            if (granted) begin
               if (split) begin
                  next_mem_out.addr = hi_addr;
                  next_mem_out.be = hi_be;
                  next_mem_out.wdata = hi_wdata;
                  next_state = LSP_REQ_HI;
               end else begin
                  next_state = LSP_WAIT;
               end
            end
         end
         LSP_REQ_HI: begin
            if (granted) begin
               next_state = LSP_WAIT;
            end
         end
         LSP_WAIT: begin
            if (outst == 2'h0) begin
               next_state = LSP_IDLE;
            end
         end
      endcase
      // First response of a split is the low part
      if (mem_rvalid && outst != 2'h0) begin
         if (split && !got_lo) begin
            next_got_lo = 1'b1;
            next_lo_data = mem_rdata;
         end else begin
            next_res_v = 1'b1;
            if (wr) begin
               next_res.rdata = 32'h0;
            end else begin
               unique case (size)
                  LSP_SIZE_BYTE: next_res.rdata = {{24{sext & rd_shift[7]}}, rd_shift[7:0]};
                  LSP_SIZE_HALF: next_res.rdata = {{16{sext & rd_shift[15]}}, rd_shift[15:0]};
                  default: next_res.rdata = rd_shift;
               endcase
            end
         end
      end
      if (accept) begin
         next_res.base_wb_en = custom_isa_extension_enable && op.post_inc;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= LSP_IDLE;
         mem_out_r <= '0;
         hi_addr <= '0;
         hi_be <= '0;
         hi_wdata <= '0;
         split <= 1'b0;
         ofs <= 2'h0;
         size <= LSP_SIZE_WORD;
         sext <= 1'b0;
         wr <= 1'b0;
         lo_data <= '0;
         got_lo <= 1'b0;
         outst <= LSP_OUT_CNT_RST;
         res_v <= 1'b0;
         res_r <= '0;
      end else begin
         state <= next_state;
         mem_out_r <= next_mem_out;
         hi_addr <= next_hi_addr;
         hi_be <= next_hi_be;
         hi_wdata <= next_hi_wdata;
         split <= next_split;
         ofs <= next_ofs;
         size <= next_size;
         sext <= next_sext;
         wr <= next_wr;
         lo_data <= next_lo_data;
         got_lo <= next_got_lo;
         outst <= next_outst;
         res_v <= next_res_v;
         res_r <= next_res;
      end
   end

   AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req && !mem_gnt |=> mem_req)
      else $error("request dropped before grant");
   AST_ADDR_STABLE: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req && !mem_gnt |=> $stable(mem_out))
      else $error("address phase changed while pending");
   AST_MAX_OUT: assert property (@(posedge core_clk) disable iff (sys_rst)
      outst <= 2'(LSP_MAX_OUTSTANDING))
      else $error("too many outstanding transactions");
   AST_WE_MATCH: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req |-> mem_out.we == wr)
      else $error("write enable does not match operation");
   AST_BE_NONZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req |-> mem_out.be != LSP_BE_NONE)
      else $error("request with no byte enabled");
   AST_WORD_ADDR: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req |-> mem_out.addr[1:0] == LSP_WORD_OFS_W)
      else $error("bus address not word aligned");
   AST_SPLIT_ORDER: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == LSP_REQ_LO && granted && split |=> mem_req && mem_out.addr == $past(mem_out.addr) + 32'h4)
      else $error("split high part not at next word");
   AST_SINGLE: assert property (@(posedge core_clk) disable iff (sys_rst)
      state == LSP_REQ_LO && granted && !split |=> !mem_req)
      else $error("unsplit access issued twice");
   AST_ACCEPT: assert property (@(posedge core_clk) disable iff (sys_rst)
      mem_req && !mem_gnt |=> outst == $past(outst) - 2'($past(mem_rvalid) && $past(outst) != 2'h0))
      else $error("count moved without grant");
   AST_BASE_WB: assert property (@(posedge core_clk) disable iff (sys_rst)
      accept |=> res_r.base_wb == $past(op.base) + $past(op.offset))
      else $error("post increment writeback wrong");

endmodule
`default_nettype wire

// *** rtl/lsp_pkg.sv ***
`default_nettype none
package lsp_pkg;

   localparam int LSP_ADDR_W = 32;
   localparam int LSP_DATA_W = 32;
   localparam int LSP_BE_W = 4;
   localparam int LSP_MAX_OUTSTANDING = 2;
   localparam logic [1:0] LSP_OUT_CNT_RST = 2'h0;
   localparam logic [3:0] LSP_BE_NONE = 4'h0;
   localparam logic [3:0] LSP_BE_WORD = 4'hf;
   localparam logic [3:0] LSP_BE_HALF = 4'h3;
   localparam logic [3:0] LSP_BE_BYTE = 4'h1;
   localparam logic [1:0] LSP_WORD_OFS_W = 2'h0;

   typedef enum logic [1:0] {
      LSP_SIZE_BYTE,
      LSP_SIZE_HALF,
      LSP_SIZE_WORD
   } lsp_size_e;

   // Core-side operation request
   typedef struct packed {
      logic [31:0] base;
      logic [31:0] offset;
      logic post_inc;
      logic write;
      lsp_size_e size;
      logic sign_ext;
      logic [31:0] wdata;
   } lsp_op_s;

   // Bus address phase
   typedef struct packed {
      logic [31:0] addr;
      logic we;
      logic [3:0] be;
      logic [31:0] wdata;
   } lsp_addr_s;

   // Core-side result
   typedef struct packed {
      logic [31:0] rdata;
      logic [31:0] base_wb;
      logic base_wb_en;
   } lsp_res_s;

endpackage
`default_nettype wire

// *** verif/lsp_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module lsp_mem_model
   import lsp_pkg::*;
(
   input wire logic core_clk, // Clock
   input wire logic sys_rst, // Sync reset
   input wire logic slow, // Random stalls
   input wire logic mem_req, // Request
   output logic mem_gnt, // Grant
   input wire lsp_addr_s mem_out, // Address phase
   output logic mem_rvalid, // Response pulse
   output logic [31:0] mem_rdata // Read data
);
   logic [31:0] m [16];
   logic [31:0] q [$];
   int seed = 42;
   initial mem_rdata = 32'h5a5a_5a5a;
   always @(posedge core_clk) begin
      // Grant may come with no request pending
      mem_gnt <= !slow || ($random(seed) & 1);
      if (sys_rst) begin
         q.delete();
         mem_rvalid <= 1'b0;
      end else begin
         // Popped before the push, so never in the grant cycle
         if (q.size() > 0 && (!slow || ($random(seed) & 1))) begin
            mem_rvalid <= 1'b1;
            mem_rdata <= q.pop_front();
         end else begin
            mem_rvalid <= 1'b0;
            mem_rdata <= ~mem_rdata;
         end
         if (mem_req && mem_gnt) begin
            if (mem_out.we) begin
               for (int i = 0; i < 4; i++) begin
                  if (mem_out.be[i]) m[mem_out.addr[5:2]][8*i+:8] = mem_out.wdata[8*i+:8];
               end
               q.push_back(~mem_out.wdata);
            end else begin
               q.push_back(m[mem_out.addr[5:2]]);
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench
   import lsp_pkg::*;
;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic op_valid = 1'b0;
   logic slow = 1'b0;
   logic op_ready, res_valid, mem_req, mem_gnt, mem_rvalid;
   lsp_op_s op = '0;
   lsp_op_s o;
   lsp_res_s res;
   lsp_addr_s mem_out, last;
   logic [31:0] mem_rdata;
   int err_count = 0, n_tests = 0, seed = 42, outst = 0, i;
   bit pend = 0;
   logic [7:0] tm [64];
   logic [31:0] rq [$], wq [$];
   logic [36:0] aq [$];

   always #4 core_clk = ~core_clk;

   lsp_load_store_unit #(.custom_isa_extension_enable(1'b1)) i_lsp_load_store_unit (
      .core_clk(core_clk), .sys_rst(sys_rst), .op_valid(op_valid), .op_ready(op_ready),
      .op(op), .res_valid(res_valid), .res(res), .mem_req(mem_req), .mem_gnt(mem_gnt),
      .mem_out(mem_out), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
   lsp_mem_model i_lsp_mem_model (
      .core_clk(core_clk), .sys_rst(sys_rst), .slow(slow), .mem_req(mem_req),
      .mem_gnt(mem_gnt), .mem_out(mem_out), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

   task check(input string what, input logic [36:0] seen, input logic [36:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_sim;
      $display("Checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Notes expected bus parts and result, then offers the operation
   task do_op(input lsp_op_s p);
      logic [31:0] ea, v;
      logic [7:0] be;
      int n, k;
      n = 1 << p.size;
      ea = p.post_inc ? p.base : p.base + p.offset;
      be = 8'((1 << n) - 1) << ea[1:0];
      v = '0;
      for (k = n - 1; k >= 0; k--) begin
         v = (v << 8) | 32'(tm[6'(ea + k)]);
         if (p.write) tm[6'(ea + k)] = p.wdata[8*k+:8];
      end
      if (p.sign_ext && n < 4 && v[8*n-1]) v = v | ~((32'h1 << 8 * n) - 1);
      rq.push_back(p.write ? 32'h0 : v);
      aq.push_back({ea & ~32'h3, p.write, be[3:0]});
      if (be[7:4] != 4'h0) aq.push_back({(ea & ~32'h3) + 32'h4, p.write, be[7:4]});
      if (p.post_inc) wq.push_back(p.base + p.offset);
      @(posedge core_clk);
      op_valid <= 1'b1;
      op <= p;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (op_ready !== 1'b1 && k < 200);
      if (op_ready !== 1'b1) begin
         err_count++;
         end_sim();
      end
      @(posedge core_clk);
      op_valid <= 1'b0;
   endtask

   // Sampled mid-cycle, where the next edge will take the values
   always @(negedge core_clk) begin
      if (!sys_rst) begin
         if (pend) check("held", {mem_req, mem_out === last}, 37'h3);
         if ((mem_req && mem_gnt) !== 1'b0) check("bus", {mem_out.addr, mem_out.we, mem_out.be}, aq.pop_front());
         outst = outst + int'(mem_req && mem_gnt) - int'(mem_rvalid);
         if (outst > 2) check("outstanding", 37'(outst), 37'h2);
         if (res_valid !== 1'b0) check("rdata", 37'(res.rdata), 37'(rq.pop_front()));
         if (res.base_wb_en !== 1'b0) check("base_wb", 37'(res.base_wb), 37'(wq.pop_front()));
         pend = mem_req && !mem_gnt;
         last = mem_out;
      end
   end

   initial begin
      for (i = 0; i < 64; i++) begin
         tm[i] = 8'(i * 37 + 5);
         i_lsp_mem_model.m[i / 4][8*(i%4)+:8] = tm[i];
      end
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 400; i++) begin
         o.base = $random(seed);
         o.offset = $random(seed) & 32'hf;
         o.post_inc = $random(seed);
         o.write = $random(seed);
         o.size = lsp_size_e'(($random(seed) & 32'hff) % 3);
         o.sign_ext = $random(seed);
         o.wdata = $random(seed);
         slow <= (i >= 150);
         do_op(o);
      end
      for (i = 0; i < 200 && (rq.size() > 0 || wq.size() > 0 || aq.size() > 0); i++) @(negedge core_clk);
      if (i == 200) err_count++;
      end_sim();
   end
endmodule
`default_nettype wire
